// File: hdl/stepper_fault_stall_config_regs.sv
// Fault, lock, blanking, stall and filter configuration registers of the stepper driver
module stepper_fault_stall_config_regs
    import stall_cfg_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           rstn,
    input  wire stall_cfg_pkg::reg_write_type   wr,
    input  wire logic [7:0]                     rd_addr,
    output logic [7:0]                          rd_data_q,
    input  wire stall_cfg_pkg::fault_event_type events,
    input  wire logic                           stall_learn_done,
    input  wire logic                           sleep_in_n,
    input  wire logic [11:0]                    torque_count_raw,
    output logic [14:0]                         torque_count_q,
    output logic                                stall_learn_start_q,
    output stall_cfg_pkg::config_type           cfg_q,
    output logic                                fault_out_n
);

    logic [7:0]      fault_lock_q;
    logic [7:0]      fault_lock_d;
    logic [7:0]      blank_stall_q;
    logic [7:0]      blank_stall_d;
    logic [7:0]      thresh_low_q;
    logic [7:0]      thresh_low_d;
    logic [7:0]      ripple_high_q;
    logic [7:0]      ripple_high_d;
    logic            locked;
    logic            clear_pulse;
    logic            sleep_sync;
    logic            sleep_prev_q;
    logic            sleep_pulse;
    logic            learn_start_d;
    logic            learn_sync;
    logic            oc_fault;
    logic            ts_fault;
    logic            stall_event;
    logic            warn_event;
    logic [7:0]      rd_data_d;
    logic [14:0]     torque_d;
    logic            fault_n_d;
    fault_event_type ev_sync;
    config_type      cfg_d;

    // Pins and analog events cross into the clock domain
    sync_two_ff #(.RESET_VALUE(1'b1)) u_sync_sleep (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (sleep_in_n),
        .sync_out (sleep_sync)
    );

    sync_two_ff u_sync_oc (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (events.overcurrent),
        .sync_out (ev_sync.overcurrent)
    );

    sync_two_ff u_sync_ot (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (events.overtemp),
        .sync_out (ev_sync.overtemp)
    );

    sync_two_ff u_sync_tw (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (events.temp_warning),
        .sync_out (ev_sync.temp_warning)
    );

    sync_two_ff u_sync_st (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (events.stall),
        .sync_out (ev_sync.stall)
    );

    // Learner completion comes from another block, so it is synchronised too
    sync_two_ff u_sync_ld (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (stall_learn_done),
        .sync_out (learn_sync)
    );

    assign locked = (fault_lock_q[LOCK_MSB:LOCK_LSB] == LOCK_PATTERN);
    // Rising edge of sleep input ends a reset pulse
    assign sleep_pulse = sleep_sync && !sleep_prev_q;
    assign clear_pulse = (wr.valid && wr.addr == ADDR_FAULT_LOCK && wr.data[FAULT_CLEAR_BIT])
                         || sleep_pulse;

    // Register write decode with lock filtering
    always_comb begin
        fault_lock_d  = fault_lock_q;
        blank_stall_d = blank_stall_q;
        thresh_low_d  = thresh_low_q;
        ripple_high_d = ripple_high_q;
        fault_lock_d[FAULT_CLEAR_BIT] = 1'b0;
        learn_start_d = 1'b0;
        if (learn_sync) begin
            blank_stall_d[STALL_LEARN_BIT] = 1'b0;
        end
        if (wr.valid) begin
            unique case (wr.addr)
                ADDR_FAULT_LOCK: begin
                    if (locked) begin
                        if (wr.data[LOCK_MSB:LOCK_LSB] == UNLOCK_PATTERN) begin
                            fault_lock_d[LOCK_MSB:LOCK_LSB] = UNLOCK_PATTERN;
                        end
                    end else begin
                        fault_lock_d[3:0] = wr.data[3:0];
                        if (wr.data[LOCK_MSB:LOCK_LSB] == LOCK_PATTERN) begin
                            fault_lock_d[LOCK_MSB:LOCK_LSB] = LOCK_PATTERN;
                        end
                    end
                end
                ADDR_BLANK_STALL: begin
                    if (!locked) begin
                        blank_stall_d = wr.data;
                        learn_start_d = wr.data[STALL_LEARN_BIT];
                        if (!wr.data[STALL_LEARN_BIT]) begin
                            blank_stall_d[STALL_LEARN_BIT] = blank_stall_q[STALL_LEARN_BIT] && !learn_sync;
                        end
                    end
                end
                ADDR_THRESH_LOW: begin
                    if (!locked) begin
                        thresh_low_d = wr.data;
                    end
                end
                ADDR_RIPPLE_HIGH: begin
                    if (!locked) begin
                        ripple_high_d = wr.data;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fault_lock_q        <= RESET_FAULT_LOCK;
            blank_stall_q       <= RESET_BLANK_STALL;
            thresh_low_q        <= RESET_THRESH_LOW;
            ripple_high_q       <= RESET_RIPPLE_HIGH;
            stall_learn_start_q <= 1'b0;
            sleep_prev_q        <= 1'b1;
        end else begin
            fault_lock_q        <= fault_lock_d;
            blank_stall_q       <= blank_stall_d;
            thresh_low_q        <= thresh_low_d;
            ripple_high_q       <= ripple_high_d;
            stall_learn_start_q <= learn_start_d;
            sleep_prev_q        <= sleep_sync;
        end
    end

    // Latched faults; auto-retry clears as soon as the condition goes
    fault_latch u_oc_latch (
        .clock      (clock),
        .rstn       (rstn),
        .event_in   (ev_sync.overcurrent),
        .auto_retry (fault_lock_q[OC_RECOVERY_BIT]),
        .clear      (clear_pulse),
        .fault_q    (oc_fault)
    );
    fault_latch u_ts_latch (
        .clock      (clock),
        .rstn       (rstn),
        .event_in   (ev_sync.overtemp),
        .auto_retry (fault_lock_q[TS_RECOVERY_BIT]),
        .clear      (clear_pulse),
        .fault_q    (ts_fault)
    );
    // Stall is latched only while detection is on
    fault_latch u_stall_latch (
        .clock      (clock),
        .rstn       (rstn),
        .event_in   (ev_sync.stall && blank_stall_q[STALL_EN_BIT]),
        .auto_retry (1'b0),
        .clear      (clear_pulse),
        .fault_q    (stall_event)
    );
    assign warn_event = ev_sync.temp_warning;

    // Decoded config, read mux and fault output
    always_comb begin
        cfg_d.oc_deglitch_cycles = fault_lock_q[OC_DEGLITCH_BIT] ? OC_DEGLITCH_LONG_CYC
                                                                 : OC_DEGLITCH_SHORT_CYC;
        cfg_d.oc_recovery = fault_lock_q[OC_RECOVERY_BIT];
        cfg_d.ts_recovery = fault_lock_q[TS_RECOVERY_BIT];
        unique case (blank_stall_q[BLANK_MSB:BLANK_LSB])
            2'h0: cfg_d.blanking_cycles = BLANK_CYC_0;
            2'h1: cfg_d.blanking_cycles = BLANK_CYC_1;
            2'h2: cfg_d.blanking_cycles = BLANK_CYC_2;
            2'h3: cfg_d.blanking_cycles = BLANK_CYC_3;
        endcase
        cfg_d.stall_detect_enable     = blank_stall_q[STALL_EN_BIT];
        cfg_d.step_filter_bypass      = blank_stall_q[FILTER_BYPASS_BIT];
        cfg_d.step_tolerance          = blank_stall_q[TOL_MSB:TOL_LSB];
        cfg_d.stall_threshold         = {ripple_high_q[THRESH_HI_MSB:0], thresh_low_q};
        cfg_d.ripple_select           = ripple_high_q[RIPPLE_MSB:RIPPLE_LSB];
        cfg_d.spread_spectrum_disable = ripple_high_q[SSC_DIS_BIT];
        cfg_d.torque_scale            = ripple_high_q[TORQUE_SCALE_BIT];
        // Scaled count keeps full width; downstream picks its own bits
        torque_d = ripple_high_q[TORQUE_SCALE_BIT] ? {torque_count_raw, 3'h0} : {3'h0, torque_count_raw};
        unique case (rd_addr)
            ADDR_FAULT_LOCK:  rd_data_d = fault_lock_q;
            ADDR_BLANK_STALL: rd_data_d = blank_stall_q;
            ADDR_THRESH_LOW:  rd_data_d = thresh_low_q;
            ADDR_RIPPLE_HIGH: rd_data_d = ripple_high_q;
            default:          rd_data_d = 8'h00;
        endcase
        fault_n_d = !(oc_fault || ts_fault
                      || (warn_event && fault_lock_q[TW_REPORT_BIT])
                      || (stall_event && blank_stall_q[STALL_REPORT_BIT]));
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data_q      <= 8'h00;
            torque_count_q <= 15'h0000;
            cfg_q          <= '0;
            fault_out_n    <= 1'b1;
        end else begin
            rd_data_q      <= rd_data_d;
            torque_count_q <= torque_d;
            cfg_q          <= cfg_d;
            fault_out_n    <= fault_n_d;
        end
    end

    // Checks next to the logic
    clear_self_a: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> !fault_lock_q[FAULT_CLEAR_BIT]) else $error("fault_clear not self clearing");
    lock_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        locked && wr.valid && wr.addr == ADDR_THRESH_LOW |=> $stable(thresh_low_q))
        else $error("write passed while locked");
    unlock_only_a: assert property (@(posedge clock) disable iff (!rstn)
        locked && !(wr.valid && wr.addr == ADDR_FAULT_LOCK && wr.data[LOCK_MSB:LOCK_LSB] == UNLOCK_PATTERN)
        |=> locked) else $error("lock left without unlock pattern");
    deglitch_sel_a: assert property (@(posedge clock) disable iff (!rstn)
        fault_lock_q[OC_DEGLITCH_BIT] |=> cfg_q.oc_deglitch_cycles == OC_DEGLITCH_LONG_CYC)
        else $error("deglitch select wrong");
    oc_latched_a: assert property (@(posedge clock) disable iff (!rstn)
        oc_fault && !fault_lock_q[OC_RECOVERY_BIT] && !clear_pulse |=> oc_fault)
        else $error("overcurrent fault not latched");
    ts_retry_a: assert property (@(posedge clock) disable iff (!rstn)
        fault_lock_q[TS_RECOVERY_BIT] && !ev_sync.overtemp |=> !ts_fault)
        else $error("thermal auto retry failed");
    fault_pin_a: assert property (@(posedge clock) disable iff (!rstn)
        oc_fault |=> !fault_out_n) else $error("fault output not asserted");
    threshold_map_a: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> cfg_q.stall_threshold == {$past(ripple_high_q[THRESH_HI_MSB:0]), $past(thresh_low_q)})
        else $error("stall threshold mapping wrong");
    learn_clear_a: assert property (@(posedge clock) disable iff (!rstn)
        learn_sync && !(wr.valid && wr.addr == ADDR_BLANK_STALL) |=> !blank_stall_q[STALL_LEARN_BIT])
        else $error("stall_learn not cleared");

    // Lock entry, clearing, masking and decode paths
    lock_engage_a: assert property (@(posedge clock) disable iff (!rstn)
        !locked && wr.valid && wr.addr == ADDR_FAULT_LOCK && wr.data[LOCK_MSB:LOCK_LSB] == LOCK_PATTERN
        |=> locked) else $error("lock pattern did not lock");
    clear_release_a: assert property (@(posedge clock) disable iff (!rstn)
        clear_pulse && !ev_sync.overcurrent |=> !oc_fault)
        else $error("fault clear did not release");
    ts_latched_a: assert property (@(posedge clock) disable iff (!rstn)
        ts_fault && !fault_lock_q[TS_RECOVERY_BIT] && !clear_pulse |=> ts_fault)
        else $error("thermal fault not latched");
    stall_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        !blank_stall_q[STALL_EN_BIT] && !stall_event |=> !stall_event)
        else $error("stall latched while disabled");
    warn_mask_a: assert property (@(posedge clock) disable iff (!rstn)
        !fault_lock_q[TW_REPORT_BIT] && !oc_fault && !ts_fault && !stall_event |=> fault_out_n)
        else $error("warning reported while masked");
    learn_start_a: assert property (@(posedge clock) disable iff (!rstn)
        stall_learn_start_q |-> blank_stall_q[STALL_LEARN_BIT])
        else $error("learn start without learn bit");
    blank_decode_a: assert property (@(posedge clock) disable iff (!rstn)
        blank_stall_q[BLANK_MSB:BLANK_LSB] == 2'h3 |=> cfg_q.blanking_cycles == BLANK_CYC_3)
        else $error("blanking decode wrong");

endmodule : stepper_fault_stall_config_regs

// File: shared/stall_cfg_pkg.sv
// Package: register map, field layout, reset values and timing counts for the fault/stall config bank
package stall_cfg_pkg;

    localparam int unsigned CLOCK_HZ = 50_000_000;

    // Register offsets
    localparam logic [7:0] ADDR_FAULT_LOCK = 8'h06;
    localparam logic [7:0] ADDR_BLANK_STALL = 8'h07;
    localparam logic [7:0] ADDR_THRESH_LOW = 8'h08;
    localparam logic [7:0] ADDR_RIPPLE_HIGH = 8'h09;

    // Reset values
    localparam logic [7:0] RESET_FAULT_LOCK = 8'h38;
    localparam logic [7:0] RESET_BLANK_STALL = 8'h49;
    localparam logic [7:0] RESET_THRESH_LOW = 8'h03;
    localparam logic [7:0] RESET_RIPPLE_HIGH = 8'h20;

    // Field positions in fault_lock_protection_ctrl
    localparam int unsigned FAULT_CLEAR_BIT = 7;
    localparam int unsigned LOCK_MSB = 6;
    localparam int unsigned LOCK_LSB = 4;
    localparam int unsigned OC_DEGLITCH_BIT = 3;
    localparam int unsigned OC_RECOVERY_BIT = 2;
    localparam int unsigned TS_RECOVERY_BIT = 1;
    localparam int unsigned TW_REPORT_BIT = 0;

    // Field positions in blanking_stall_filter_ctrl
    localparam int unsigned BLANK_MSB = 7;
    localparam int unsigned BLANK_LSB = 6;
    localparam int unsigned STALL_LEARN_BIT = 5;
    localparam int unsigned STALL_EN_BIT = 4;
    localparam int unsigned STALL_REPORT_BIT = 3;
    localparam int unsigned FILTER_BYPASS_BIT = 2;
    localparam int unsigned TOL_MSB = 1;
    localparam int unsigned TOL_LSB = 0;

    // Field positions in ripple_spread_threshold_high
    localparam int unsigned RIPPLE_MSB = 7;
    localparam int unsigned RIPPLE_LSB = 6;
    localparam int unsigned SSC_DIS_BIT = 5;
    localparam int unsigned TORQUE_SCALE_BIT = 4;
    localparam int unsigned THRESH_HI_MSB = 3;

    // Lock patterns
    localparam logic [2:0] LOCK_PATTERN = 3'h6;
    localparam logic [2:0] UNLOCK_PATTERN = 3'h3;

    // Deglitch times in ns and their cycle counts (least times, round up)
    localparam int unsigned OC_DEGLITCH_LONG_NS = 2200;
    localparam int unsigned OC_DEGLITCH_SHORT_NS = 1200;
    localparam int unsigned NS_PER_S = 1_000_000_000;
    localparam logic [7:0] OC_DEGLITCH_LONG_CYC =
        8'((64'(OC_DEGLITCH_LONG_NS) * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] OC_DEGLITCH_SHORT_CYC =
        8'((64'(OC_DEGLITCH_SHORT_NS) * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);

    // Blanking times in ns, indexed by field code
    localparam int unsigned BLANK_1000_NS = 1000;
    localparam int unsigned BLANK_1500_NS = 1500;
    localparam int unsigned BLANK_2000_NS = 2000;
    localparam int unsigned BLANK_2500_NS = 2500;
    localparam logic [7:0] BLANK_CYC_0 = 8'((64'(BLANK_1000_NS) * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] BLANK_CYC_1 = 8'((64'(BLANK_1500_NS) * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] BLANK_CYC_2 = 8'((64'(BLANK_2000_NS) * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] BLANK_CYC_3 = 8'((64'(BLANK_2500_NS) * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);

    // Register write request
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_type;

    // Fault event inputs from the analog protection blocks
    typedef struct packed {
        logic overcurrent;
        logic overtemp;
        logic temp_warning;
        logic stall;
    } fault_event_type;

    // Decoded configuration outputs
    typedef struct packed {
        logic [7:0]  oc_deglitch_cycles;
        logic        oc_recovery;
        logic        ts_recovery;
        logic [7:0]  blanking_cycles;
        logic        stall_detect_enable;
        logic        step_filter_bypass;
        logic [1:0]  step_tolerance;
        logic [11:0] stall_threshold;
        logic [1:0]  ripple_select;
        logic        spread_spectrum_disable;
        logic        torque_scale;
    } config_type;

endpackage : stall_cfg_pkg

// File: hdl/sync_two_ff.sv
// Two flip-flop synchroniser for one level input
module sync_two_ff #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic async_in,
    output logic      sync_out
);

    logic first_q;
    logic first_d;
    logic second_d;

    // First stage feeds only the second
    always_comb begin
        first_d  = async_in;
        second_d = first_q;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            first_q  <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            first_q  <= first_d;
            sync_out <= second_d;
        end
    end

endmodule : sync_two_ff

// File: hdl/fault_latch.sv
// One fault flag with latched or auto-retry recovery
module fault_latch (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic event_in,
    input  wire logic auto_retry,
    input  wire logic clear,
    output logic      fault_q
);

    logic fault_d;

    // Set wins over clear so an event in the clear cycle is kept
    always_comb begin
        if (event_in) begin
            fault_d = 1'b1;
        end else if (auto_retry || clear) begin
            fault_d = 1'b0;
        end else begin
            fault_d = fault_q;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

endmodule : fault_latch

// File: dv/reg_host.sv
// Host controller model: register writes, registered reads and the sleep pin
module reg_host
    import stall_cfg_pkg::*;
(
    input  wire logic                         clock,
    output stall_cfg_pkg::reg_write_type      wr,
    output logic [7:0]                        rd_addr,
    output logic                              sleep_in_n,
    input  wire logic [7:0]                   rd_data_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero, sleep pin awake
    initial begin
        wr = '0;
        rd_addr = 8'h00;
        sleep_in_n = 1'b1;
    end

    // One-cycle strobe; released fields show inverted junk, not the last value
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= '{valid: 1'b1, addr: a, data: d};
        @(posedge clock);
        wr <= '{valid: 1'b0, addr: ~a, data: ~d};
    endtask

    // Read data is registered, so it is taken one edge after the address
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        rd_addr <= a;
        @(posedge clock);
        #1;
        d = rd_data_q;
    endtask

    // Low pulse long enough to pass the input synchroniser
    task automatic sleep_pulse();
        @(posedge clock);
        sleep_in_n <= 1'b0;
        repeat (4) @(posedge clock);
        sleep_in_n <= 1'b1;
    endtask
endmodule // reg_host

// File: dv/stepper_fault_stall_config_regs_bench.sv
// Self-checking bench for the fault, lock and stall configuration registers
module stepper_fault_stall_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import stall_cfg_pkg::*;
    logic            clock;
    logic            rstn;
    reg_write_type   wr;
    logic [7:0]      rd_addr;
    logic [7:0]      rd_data_q;
    fault_event_type events;
    logic            stall_learn_done;
    logic            sleep_in_n;
    logic [11:0]     torque_count_raw;
    logic [14:0]     torque_count_q;
    logic            stall_learn_start_q;
    config_type      cfg_q;
    logic            fault_out_n;
    int              n_fail = 0;
    int              tests_run = 0;
    int              cycles = 0;
    int              n_start = 0;
    logic [7:0]      got;
    logic [7:0]      d8;
    logic [7:0]      d9;
    logic [11:0]     r;
    logic [1:0]      cc;
    logic [3:0]      ev;
    logic [7:0]      rec;

    stepper_fault_stall_config_regs u_dut (.clock(clock), .rstn(rstn), .wr(wr), .rd_addr(rd_addr),
        .rd_data_q(rd_data_q), .events(events), .stall_learn_done(stall_learn_done),
        .sleep_in_n(sleep_in_n), .torque_count_raw(torque_count_raw), .torque_count_q(torque_count_q),
        .stall_learn_start_q(stall_learn_start_q), .cfg_q(cfg_q), .fault_out_n(fault_out_n));
    reg_host u_host (.clock(clock), .wr(wr), .rd_addr(rd_addr), .sleep_in_n(sleep_in_n),
        .rd_data_q(rd_data_q));

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    // Count learn start pulses; catches a level instead of a pulse
    always @(posedge clock) begin
        if (stall_learn_start_q === 1'b1) n_start++;
    end

    // Time to cycle count at 20 ns, rounded up
    function automatic logic [7:0] ns_to_cyc(input int ns);
        return 8'((ns + 19) / 20);
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic set_ev(input logic [3:0] v);
        @(posedge clock);
        events <= fault_event_type'(v);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        u_host.read_reg(a, got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t reg %h read %h want %h", $time, a, got, exp);
        end
    endtask

    task automatic chk_val(input logic [15:0] g, input logic [15:0] exp);
        tests_run++;
        if (g !== exp) begin
            n_fail++;
            $display("BAD %0t value %h want %h", $time, g, exp);
        end
    endtask

    task automatic chk_pin(input logic exp);
        tests_run++;
        if (fault_out_n !== exp) begin
            n_fail++;
            $display("BAD %0t fault pin %b want %b", $time, fault_out_n, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        events = '0;
        stall_learn_done = 1'b0;
        torque_count_raw = 12'h000;
        void'($urandom(92));
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        // Reset values and reset decode
        wait_cyc(2);
        chk_reg(ADDR_FAULT_LOCK, 8'h38);
        chk_reg(ADDR_BLANK_STALL, 8'h49);
        chk_reg(ADDR_THRESH_LOW, 8'h03);
        chk_reg(ADDR_RIPPLE_HIGH, 8'h20);
        chk_reg(8'h0a, 8'h00);
        chk_val(16'(cfg_q.oc_deglitch_cycles), 16'(ns_to_cyc(2200)));
        chk_val(16'(cfg_q.blanking_cycles), 16'(ns_to_cyc(1500)));
        chk_val(16'(cfg_q.stall_threshold), 16'h0003);
        chk_pin(1'b1);
        $display("test reset done");
        // Every blanking, tolerance and deglitch code
        for (int c = 0; c < 4; c++) begin
            cc = 2'(c);
            u_host.write_reg(ADDR_BLANK_STALL, {cc, 3'b001, cc[0], cc});
            chk_reg(ADDR_BLANK_STALL, {cc, 3'b001, cc[0], cc});
            chk_val(16'(cfg_q.blanking_cycles), 16'(ns_to_cyc(1000 + 500 * c)));
            chk_val(16'({cfg_q.step_filter_bypass, cfg_q.step_tolerance}), 16'({cc[0], cc}));
            u_host.write_reg(ADDR_FAULT_LOCK, {4'h3, cc[0], cc[0], ~cc[0], 1'b0});
            // Decoded config lags the register by one stage
            wait_cyc(2);
            chk_val(16'(cfg_q.oc_deglitch_cycles), 16'(ns_to_cyc(cc[0] ? 2200 : 1200)));
            chk_val(16'({cfg_q.oc_recovery, cfg_q.ts_recovery}), 16'({cc[0], ~cc[0]}));
        end
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h38);
        $display("test decode done");
        // Random threshold, ripple, spread spectrum and torque scaling
        for (int i = 0; i < 12; i++) begin
            d8 = 8'($urandom);
            d9 = 8'($urandom);
            r = 12'($urandom);
            u_host.write_reg(ADDR_THRESH_LOW, d8);
            u_host.write_reg(ADDR_RIPPLE_HIGH, d9);
            torque_count_raw <= r;
            chk_reg(ADDR_THRESH_LOW, d8);
            chk_reg(ADDR_RIPPLE_HIGH, d9);
            chk_val(16'(cfg_q.stall_threshold), 16'({d9[3:0], d8}));
            chk_val(16'({cfg_q.ripple_select, cfg_q.spread_spectrum_disable}), 16'(d9[7:5]));
            chk_val(16'(cfg_q.torque_scale), 16'(d9[4]));
            chk_val(16'(torque_count_q), d9[4] ? 16'({r, 3'b000}) : 16'(r));
        end
        $display("test threshold done");
        // Lock, ignored patterns, silent drops and unlock
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h58);
        chk_reg(ADDR_FAULT_LOCK, 8'h38);
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h68);
        u_host.write_reg(ADDR_THRESH_LOW, ~d8);
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h60);
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h58);
        chk_reg(ADDR_THRESH_LOW, d8);
        chk_reg(ADDR_FAULT_LOCK, 8'h68);
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h38);
        u_host.write_reg(ADDR_THRESH_LOW, ~d8);
        chk_reg(ADDR_THRESH_LOW, ~d8);
        $display("test lock done");
        // Latched and auto-retry recovery for overcurrent and overtemperature
        for (int k = 0; k < 2; k++) begin
            ev = k ? 4'b0100 : 4'b1000;
            rec = k ? 8'h02 : 8'h04;
            set_ev(ev);
            wait_cyc(8);
            chk_pin(1'b0);
            set_ev(4'b0000);
            wait_cyc(8);
            chk_pin(1'b0);
            u_host.write_reg(ADDR_FAULT_LOCK, 8'hb8);
            wait_cyc(8);
            chk_pin(1'b1);
            chk_reg(ADDR_FAULT_LOCK, 8'h38);
            u_host.write_reg(ADDR_FAULT_LOCK, 8'h38 | rec);
            set_ev(ev);
            wait_cyc(8);
            chk_pin(1'b0);
            set_ev(4'b0000);
            wait_cyc(8);
            chk_pin(1'b1);
            u_host.write_reg(ADDR_FAULT_LOCK, 8'h38);
        end
        // Sleep pulse releases a latched fault
        set_ev(4'b1000);
        wait_cyc(8);
        set_ev(4'b0000);
        u_host.sleep_pulse();
        wait_cyc(8);
        chk_pin(1'b1);
        // Temperature warning reported only when enabled
        set_ev(4'b0010);
        wait_cyc(8);
        chk_pin(1'b1);
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h39);
        wait_cyc(8);
        chk_pin(1'b0);
        set_ev(4'b0000);
        u_host.write_reg(ADDR_FAULT_LOCK, 8'h38);
        // Stall needs detection on, and reporting on to reach the pin
        for (int s = 0; s < 3; s++) begin
            rec = (s == 0) ? 8'h49 : ((s == 1) ? 8'h59 : 8'h51);
            u_host.write_reg(ADDR_BLANK_STALL, rec);
            set_ev(4'b0001);
            wait_cyc(8);
            chk_pin(s != 1);
            chk_val(16'(cfg_q.stall_detect_enable), 16'(rec[4]));
            set_ev(4'b0000);
            u_host.write_reg(ADDR_FAULT_LOCK, 8'hb8);
            wait_cyc(8);
        end
        $display("test faults done");
        // Learn bit holds until the learner reports completion
        u_host.write_reg(ADDR_BLANK_STALL, 8'h69);
        chk_reg(ADDR_BLANK_STALL, 8'h69);
        chk_val(16'(n_start), 16'h0001);
        @(posedge clock);
        stall_learn_done <= 1'b1;
        wait_cyc(6);
        stall_learn_done <= 1'b0;
        chk_reg(ADDR_BLANK_STALL, 8'h49);
        $display("test learn done");
        results();
    end
endmodule // stepper_fault_stall_config_regs_bench
